// >>> shared/timer_counter_regs.svh
`ifndef TIMER_COUNTER_REGS_SVH
`define TIMER_COUNTER_REGS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define CMP_A_LO_ADDR    16'h0020
`define CMP_A_HI_ADDR    16'h0021
`define CMP_B_LO_ADDR    16'h0022
`define CMP_B_HI_ADDR    16'h0023
`define TIMER_CTRL_ADDR  16'h0032

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CMP_RESET        16'h0fff
`define CTRL_RESET       8'h00

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define CTRL_OUTFF_BIT   7
`define CTRL_BIT6        6
`define CTRL_START_HI    5
`define CTRL_START_LO    4
`define CTRL_SRC_HI      3
`define CTRL_SRC_LO      2
`define CTRL_MODE_HI     1
`define CTRL_MODE_LO     0

// ----------------------------------------
// Divider taps and widths
// ----------------------------------------
`define DIV_W            13
`define TAP_SLOW         4'hb
`define TAP_MID          4'h7
`define TAP_FAST         4'h3
`define LF_DIV_W         3

`endif

// >>> shared/timer_counter_pkg.sv
package timer_counter_pkg;

   typedef enum logic [1:0] {
      MODE_TIMER,
      MODE_WINDOW,
      MODE_PULSE,
      MODE_PPG
   } opmode_t;

   typedef enum logic [1:0] {
      START_STOP,
      START_COMMAND,
      START_RISE,
      START_FALL
   } start_t;

   typedef enum logic [1:0] {
      SRC_SLOW,
      SRC_MID,
      SRC_FAST,
      SRC_EXTERNAL
   } clksrc_t;

endpackage

// >>> shared/timer_clock_if.sv
`timescale 1ns/1ns
`default_nettype none

interface timer_clock_if;
   import timer_counter_pkg::*;
   clksrc_t srcSel;
   logic    dv7;
   logic    dv1;
   logic    slowMode;
   logic    edgeFall;
   logic    srcTick;
   logic    pinLevel;
   logic    pinRise;
   logic    pinFall;

   modport source (
      input  srcSel, dv7, dv1, slowMode, edgeFall,
      output srcTick, pinLevel, pinRise, pinFall
   );

   modport user (
      output srcSel, dv7, dv1, slowMode, edgeFall,
      input  srcTick, pinLevel, pinRise, pinFall
   );
endinterface

`default_nettype wire

// >>> src/timer_clock_source.sv
`timescale 1ns/1ns
`default_nettype none
`include "timer_counter_regs.svh"

module timer_clock_source import timer_counter_pkg::*; (
   input  wire logic     sys_clk,
   input  wire logic     reset,
   input  wire logic     timerInputPin,
   input  wire logic     lowFreqClk,
   timer_clock_if.source clkIf
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [1:0]           sync1_r, sync1_nxt;
   logic [1:0]           sync2_r, sync2_nxt;
   logic [1:0]           sync3_r, sync3_nxt;
   logic [`DIV_W-1:0]    div_r, div_nxt;
   logic [`LF_DIV_W-1:0] lf_r, lf_nxt;
   logic                 tapPrev_r, tapPrev_nxt;
   logic                 tick_r, tick_nxt;
   logic                 rise_r, rise_nxt;
   logic                 fall_r, fall_nxt;
   logic                 level_r, level_nxt;
   logic                 tapBit;

   function automatic logic [3:0] tapIndex(input clksrc_t s, input logic dv1);
      logic [3:0] base;
      base = (s == SRC_SLOW) ? `TAP_SLOW : (s == SRC_MID) ? `TAP_MID : `TAP_FAST;
      return base + {3'h0, dv1};
   endfunction

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      sync1_nxt   = {lowFreqClk, timerInputPin};
      sync2_nxt   = sync1_r;
      sync3_nxt   = sync2_r;
      div_nxt     = div_r + {{(`DIV_W-1){1'b0}}, 1'b1};
      lf_nxt      = lf_r + {{(`LF_DIV_W-1){1'b0}}, sync2_r[1] & ~sync3_r[1]};
      rise_nxt    = sync2_r[0] & ~sync3_r[0];
      fall_nxt    = ~sync2_r[0] & sync3_r[0];
      level_nxt   = sync2_r[0];
      // Low-frequency tap for the slow source, in slow mode or when the divider is fed from it
      if (clkIf.srcSel == SRC_SLOW && (clkIf.slowMode || clkIf.dv7)) begin
         tapBit = lf_r[`LF_DIV_W-1];
      end else begin
         tapBit = div_r[tapIndex(clkIf.srcSel, clkIf.dv1)];
      end
      tapPrev_nxt = tapBit;
      if (clkIf.srcSel == SRC_EXTERNAL) begin
         tick_nxt = clkIf.edgeFall ? fall_nxt : rise_nxt;
      end else if (clkIf.slowMode && clkIf.srcSel != SRC_SLOW) begin
         tick_nxt = 1'b0;
      end else begin
         tick_nxt = tapBit & ~tapPrev_r;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sync1_r   <= 2'h0;
         sync2_r   <= 2'h0;
         sync3_r   <= 2'h0;
         div_r     <= '0;
         lf_r      <= '0;
         tapPrev_r <= 1'b0;
         tick_r    <= 1'b0;
         rise_r    <= 1'b0;
         fall_r    <= 1'b0;
         level_r   <= 1'b0;
      end else begin
         sync1_r   <= sync1_nxt;
         sync2_r   <= sync2_nxt;
         sync3_r   <= sync3_nxt;
         div_r     <= div_nxt;
         lf_r      <= lf_nxt;
         tapPrev_r <= tapPrev_nxt;
         tick_r    <= tick_nxt;
         rise_r    <= rise_nxt;
         fall_r    <= fall_nxt;
         level_r   <= level_nxt;
      end
   end

   assign clkIf.srcTick  = tick_r;
   assign clkIf.pinRise  = rise_r;
   assign clkIf.pinFall  = fall_r;
   assign clkIf.pinLevel = level_r;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_slow_taps_quiet: assert property (@(posedge sys_clk) disable iff (reset)
      (clkIf.slowMode && (clkIf.srcSel == SRC_MID || clkIf.srcSel == SRC_FAST)) |=> !tick_r)
      else $error("fast tap ticked in slow mode");

   chk_ext_pin_tick: assert property (@(posedge sys_clk) disable iff (reset)
      (clkIf.srcSel == SRC_EXTERNAL && !clkIf.edgeFall && sync2_r[0] && !sync3_r[0])
      |=> tick_r)
      else $error("external rising edge gave no tick");

endmodule

`default_nettype wire

// >>> src/timer_counter_control.sv
// Local design decision: strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "timer_counter_regs.svh"

// How it works
// - Timer value applies at next source tick
// - Lower byte write alone changes nothing
// - B accepts writes only in pulse output
// - Stop power mode clears start field
// - Auto-capture copies counter each source tick
// - Mode field decodes four operating modes
// - Start field: stop, command, rising, falling
// - Source field: three divider taps, pin
// - Bit six meaning depends on mode
// - Timer match raises interrupt, clears counter
module timer_counter_control import timer_counter_pkg::*; (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic [15:0] regAddr,
   input  wire logic [7:0]  regWrData,
   input  wire logic        regWrEn,
   input  wire logic        regRdEn,
   output logic      [7:0]  regRdData,
   input  wire logic        timerInputPin,
   input  wire logic        lowFreqClk,
   input  wire logic        dividerStageSelect,
   input  wire logic        prescaleSelect,
   input  wire logic        slowMode,
   input  wire logic        stopModeEntry,
   output logic             timerMatchInterrupt,
   output logic             timerOutput
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [7:0]  ctrl_r, ctrl_nxt;
   logic [15:0] holdA_r, holdA_nxt;
   logic [15:0] holdB_r, holdB_nxt;
   logic [15:0] activeA_r, activeA_nxt;
   logic [15:0] activeB_r, activeB_nxt;
   logic [15:0] counter_r, counter_nxt;
   logic        pendA_r, pendA_nxt;
   logic        pendB_r, pendB_nxt;
   logic        running_r, running_nxt;
   logic        irq_r, irq_nxt;
   logic        outFF_r, outFF_nxt;
   logic [7:0]  rdData_r, rdData_nxt;

   logic        wrALo, wrAHi, wrBLo, wrBHi, wrCtrl;
   opmode_t     mode;
   start_t      start;
   clksrc_t     src;
   logic        modeBit6;
   logic        trigOn, trigOff;
   logic        plainTimer;
   logic        autoCapture;
   logic        matchA;

   timer_clock_if clkIf ();

   function automatic logic edgeSeen(input start_t s, input logic rise, input logic fall);
      return (s == START_RISE) ? rise : (s == START_FALL) ? fall : 1'b0;
   endfunction

   // ----------------------------------------
   // Field decode
   // ----------------------------------------
   assign mode     = opmode_t'(ctrl_r[`CTRL_MODE_HI:`CTRL_MODE_LO]);
   assign start    = start_t'(ctrl_r[`CTRL_START_HI:`CTRL_START_LO]);
   assign src      = clksrc_t'(ctrl_r[`CTRL_SRC_HI:`CTRL_SRC_LO]);
   assign modeBit6 = ctrl_r[`CTRL_BIT6];
   assign trigOn   = edgeSeen(start, clkIf.pinRise, clkIf.pinFall);
   assign trigOff  = edgeSeen(start, clkIf.pinFall, clkIf.pinRise);
   // Command start or pin-clocked counting; otherwise mode 00 is trigger-started
   assign plainTimer  = mode == MODE_TIMER && (start == START_COMMAND || src == SRC_EXTERNAL);
   // Bit 6 is capture enable only where capture exists; elsewhere it is trigger stop, or one-shot stop at match in PPG
   assign autoCapture = modeBit6 && start != START_STOP
                        && (plainTimer || mode == MODE_WINDOW);
   assign matchA      = counter_r == activeA_r && mode != MODE_PULSE;

   assign clkIf.srcSel   = src;
   assign clkIf.dv7      = dividerStageSelect;
   assign clkIf.dv1      = prescaleSelect;
   assign clkIf.slowMode = slowMode;
   assign clkIf.edgeFall = start == START_FALL;

   timer_clock_source timer_clock_source_i (
      .sys_clk       (sys_clk),
      .reset         (reset),
      .timerInputPin (timerInputPin),
      .lowFreqClk    (lowFreqClk),
      .clkIf         (clkIf.source)
   );

   // ----------------------------------------
   // Write address decode
   // ----------------------------------------
   always_comb begin
      wrALo  = 1'b0;
      wrAHi  = 1'b0;
      wrBLo  = 1'b0;
      wrBHi  = 1'b0;
      wrCtrl = 1'b0;
      if (regWrEn) begin
         if (regAddr == `CMP_A_LO_ADDR) begin
            wrALo = 1'b1;
         end else if (regAddr == `CMP_A_HI_ADDR) begin
            wrAHi = 1'b1;
         end else if (regAddr == `CMP_B_LO_ADDR) begin
            wrBLo = 1'b1;
         end else if (regAddr == `CMP_B_HI_ADDR) begin
            wrBHi = 1'b1;
         end else if (regAddr == `TIMER_CTRL_ADDR) begin
            wrCtrl = 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      ctrl_nxt    = ctrl_r;
      holdA_nxt   = holdA_r;
      holdB_nxt   = holdB_r;
      activeA_nxt = activeA_r;
      activeB_nxt = activeB_r;
      counter_nxt = counter_r;
      pendA_nxt   = pendA_r;
      pendB_nxt   = pendB_r;
      running_nxt = running_r;
      irq_nxt     = 1'b0;
      outFF_nxt   = outFF_r;
      rdData_nxt  = 8'h00;

      if (wrCtrl) begin
         ctrl_nxt = regWrData;
      end
      // Holding stages; only the upper byte arms the transfer
      if (wrALo) begin
         holdA_nxt[7:0] = regWrData;
      end
      if (wrAHi) begin
         holdA_nxt[15:8] = regWrData;
         pendA_nxt       = 1'b1;
      end
      if (mode == MODE_PPG) begin
         if (wrBLo) begin
            holdB_nxt[7:0] = regWrData;
         end
         if (wrBHi) begin
            holdB_nxt[15:8] = regWrData;
            pendB_nxt       = 1'b1;
         end
      end
      // A fresh upper write in the tick cycle keeps the flag armed
      if (clkIf.srcTick && pendA_r && !wrAHi) begin
         activeA_nxt = holdA_r;
         pendA_nxt   = 1'b0;
      end
      if (clkIf.srcTick && pendB_r && !(wrBHi && mode == MODE_PPG)) begin
         activeB_nxt = holdB_r;
         pendB_nxt   = 1'b0;
      end

      if (start == START_STOP) begin
         counter_nxt = 16'h0000;
         running_nxt = 1'b0;
         outFF_nxt   = ctrl_r[`CTRL_OUTFF_BIT];
      end else begin
         case (mode)
            MODE_TIMER: begin
               if (plainTimer) begin
                  running_nxt = 1'b1;
               end else if (trigOn && !running_r) begin
                  running_nxt = 1'b1;
               end else if (trigOff && running_r && modeBit6) begin
                  running_nxt = 1'b0;
                  counter_nxt = 16'h0000;
               end
            end
            MODE_WINDOW: begin
               running_nxt = (start == START_RISE) ? clkIf.pinLevel
                           : (start == START_FALL) ? !clkIf.pinLevel : 1'b0;
            end
            MODE_PULSE: begin
               if (trigOn && !running_r) begin
                  running_nxt = 1'b1;
                  counter_nxt = 16'h0000;
               end else if (running_r && (trigOff || (trigOn && !modeBit6))) begin
                  activeB_nxt = counter_r;
                  irq_nxt     = 1'b1;
                  if (modeBit6) begin
                     running_nxt = 1'b0;
                     counter_nxt = 16'h0000;
                  end
               end
            end
            MODE_PPG: begin
               if (start == START_COMMAND || (trigOn && !running_r)) begin
                  running_nxt = 1'b1;
               end
            end
            default: begin
            end
         endcase
         if (clkIf.srcTick && running_r) begin
            if (matchA) begin
               counter_nxt = 16'h0000;
               irq_nxt     = 1'b1;
               if (mode == MODE_TIMER && !plainTimer) begin
                  running_nxt = 1'b0;
               end
               if (mode == MODE_PPG) begin
                  outFF_nxt = !outFF_r;
                  if (modeBit6) begin
                     running_nxt = 1'b0;
                     ctrl_nxt[`CTRL_START_HI:`CTRL_START_LO] = 2'b00;
                  end
               end
            end else begin
               counter_nxt = counter_r + 16'h0001;
               if (mode == MODE_PPG && counter_r == activeB_r) begin
                  outFF_nxt = !outFF_r;
               end
            end
         end
      end
      if (clkIf.srcTick && autoCapture) begin
         activeB_nxt = counter_r;
      end
      // Power-down beats a same-cycle software start
      if (stopModeEntry) begin
         ctrl_nxt[`CTRL_START_HI:`CTRL_START_LO] = 2'b00;
      end

      if (regRdEn) begin
         if (regAddr == `CMP_A_LO_ADDR) begin
            rdData_nxt = activeA_r[7:0];
         end else if (regAddr == `CMP_A_HI_ADDR) begin
            rdData_nxt = activeA_r[15:8];
         end else if (regAddr == `CMP_B_LO_ADDR) begin
            rdData_nxt = activeB_r[7:0];
         end else if (regAddr == `CMP_B_HI_ADDR) begin
            rdData_nxt = activeB_r[15:8];
         end else if (regAddr == `TIMER_CTRL_ADDR) begin
            rdData_nxt = ctrl_r;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ctrl_r    <= `CTRL_RESET;
         holdA_r   <= `CMP_RESET;
         holdB_r   <= `CMP_RESET;
         activeA_r <= `CMP_RESET;
         activeB_r <= `CMP_RESET;
         counter_r <= 16'h0000;
         pendA_r   <= 1'b0;
         pendB_r   <= 1'b0;
         running_r <= 1'b0;
         irq_r     <= 1'b0;
         outFF_r   <= 1'b0;
         rdData_r  <= 8'h00;
      end else begin
         ctrl_r    <= ctrl_nxt;
         holdA_r   <= holdA_nxt;
         holdB_r   <= holdB_nxt;
         activeA_r <= activeA_nxt;
         activeB_r <= activeB_nxt;
         counter_r <= counter_nxt;
         pendA_r   <= pendA_nxt;
         pendB_r   <= pendB_nxt;
         running_r <= running_nxt;
         irq_r     <= irq_nxt;
         outFF_r   <= outFF_nxt;
         rdData_r  <= rdData_nxt;
      end
   end

   assign regRdData           = rdData_r;
   assign timerMatchInterrupt = irq_r;
   assign timerOutput         = outFF_r;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   sequence stopForced;
      start == START_STOP;
   endsequence

   sequence counterIdle;
      counter_r == 16'h0000 && !running_r;
   endsequence

   chk_low_byte_hold: assert property (
      (wrALo && !pendA_r) |=> $stable(activeA_r))
      else $error("lower byte write changed active A");

   chk_upper_arms: assert property (
      wrAHi |=> pendA_r)
      else $error("upper byte write did not arm transfer");

   chk_tick_applies: assert property (
      (clkIf.srcTick && pendA_r && !wrAHi) |=> (activeA_r == $past(holdA_r) && !pendA_r))
      else $error("holding A not applied at source tick");

   chk_b_write_gate: assert property (
      ((wrBLo || wrBHi) && mode != MODE_PPG) |=> $stable(holdB_r))
      else $error("B accepted write outside pulse output mode");

   chk_stop_mode_clear: assert property (
      stopModeEntry |=> stopForced ##1 counterIdle)
      else $error("stop mode did not halt counter");

   chk_auto_capture: assert property (
      (clkIf.srcTick && autoCapture) |=> activeB_r == $past(counter_r))
      else $error("auto-capture missed counter value");

   chk_match_clear: assert property (
      (clkIf.srcTick && running_r && matchA && start != START_STOP && !stopModeEntry)
      |=> (counter_r == 16'h0000 && timerMatchInterrupt))
      else $error("match did not clear counter and interrupt");

   chk_stop_code_clear: assert property (
      (start == START_STOP) |=> counterIdle)
      else $error("stop code left counter running");

   chk_ctrl_readback: assert property (
      (regRdEn && regAddr == `TIMER_CTRL_ADDR) |=> regRdData == $past(ctrl_r))
      else $error("control read data wrong");

endmodule

`default_nettype wire

// >>> tb/test_timer_counter_control.sv
`timescale 1ns/1ns
`default_nettype none
`include "timer_counter_regs.svh"

module test_timer_counter_control import timer_counter_pkg::*;;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic        sys_clk;
   logic        reset;
   logic [15:0] regAddr;
   logic [7:0]  regWrData;
   logic        regWrEn;
   logic        regRdEn;
   logic [7:0]  regRdData;
   logic        timerInputPin;
   logic        lowFreqClk;
   logic        dividerStageSelect;
   logic        prescaleSelect;
   logic        slowMode;
   logic        stopModeEntry;
   logic        timerMatchInterrupt;
   logic        timerOutput;
   int          nErrors;
   int          nTests;
   int          irqCount;
   int          irqBase;

   timer_counter_control timer_counter_control_i (
      .sys_clk             (sys_clk),
      .reset               (reset),
      .regAddr             (regAddr),
      .regWrData           (regWrData),
      .regWrEn             (regWrEn),
      .regRdEn             (regRdEn),
      .regRdData           (regRdData),
      .timerInputPin       (timerInputPin),
      .lowFreqClk          (lowFreqClk),
      .dividerStageSelect  (dividerStageSelect),
      .prescaleSelect      (prescaleSelect),
      .slowMode            (slowMode),
      .stopModeEntry       (stopModeEntry),
      .timerMatchInterrupt (timerMatchInterrupt),
      .timerOutput         (timerOutput)
   );

   // ----------------------------------------
   // Clock and event counting
   // ----------------------------------------
   always #2 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      if (timerMatchInterrupt === 1'b1) begin
         irqCount <= irqCount + 1;
      end
   end

   // Low-frequency pin toggles slowly so the slow tap stays live
   always begin
      repeat (15) @(posedge sys_clk);
      lowFreqClk <= ~lowFreqClk;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic finalReport;
      $display("Comparisons %0d, mismatches %0d", nTests, nErrors);
      if (nErrors == 0 && nTests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      nTests++;
      if (got !== exp) begin
         nErrors++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Interrupts counted over a fixed window of n sys_clk cycles
   task automatic irqsIn(input int n, input int exp);
      irqBase = irqCount;
      repeat (n) @(posedge sys_clk);
      check(16'(irqCount - irqBase), 16'(exp));
   endtask

   // Single write, strobe dropped and one idle edge after
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      regAddr   <= a;
      regWrData <= d;
      regWrEn   <= 1'b1;
      @(posedge sys_clk);
      regWrEn   <= 1'b0;
      @(posedge sys_clk);
   endtask

   // Lower then upper byte back to back, strobe held high
   task automatic wr16(input logic [15:0] a, input logic [15:0] d);
      regAddr   <= a;
      regWrData <= d[7:0];
      regWrEn   <= 1'b1;
      @(posedge sys_clk);
      regAddr   <= a + 16'h0001;
      regWrData <= d[15:8];
      @(posedge sys_clk);
      regWrEn   <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge sys_clk);
      regRdEn <= 1'b0;
      @(negedge sys_clk);
      d = regRdData;
      @(posedge sys_clk);
   endtask

   task automatic rd16(input logic [15:0] a, input logic [15:0] exp);
      logic [7:0] lo;
      logic [7:0] hi;
      rd(a, lo);
      rd(a + 16'h0001, hi);
      check({hi, lo}, exp);
   endtask

   task automatic rdCtrl(input logic [7:0] exp);
      logic [7:0] v;
      rd(`TIMER_CTRL_ADDR, v);
      check({8'h00, v}, {8'h00, exp});
   endtask

   // One full pin pulse: both edges pass the two-flop synchroniser
   task automatic ticks(input int n);
      repeat (n) begin
         timerInputPin <= 1'b1;
         repeat (8) @(posedge sys_clk);
         timerInputPin <= 1'b0;
         repeat (8) @(posedge sys_clk);
      end
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [7:0] v;
      sys_clk = 1'b0;
      reset = 1'b1;
      regAddr = 16'h0000;
      regWrData = 8'h00;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      timerInputPin = 1'b0;
      lowFreqClk = 1'b0;
      dividerStageSelect = 1'b0;
      prescaleSelect = 1'b0;
      slowMode = 1'b0;
      stopModeEntry = 1'b0;
      nErrors = 0;
      nTests = 0;
      irqCount = 0;
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      rd16(`CMP_A_LO_ADDR, `CMP_RESET);
      rd16(`CMP_B_LO_ADDR, `CMP_RESET);
      rdCtrl(`CTRL_RESET);
      wr(16'h0030, 8'h5a);
      rd(16'h0030, v);
      check({8'h00, v}, 16'h0000);
      for (int m = 0; m < 4; m++) begin
         wr(`TIMER_CTRL_ADDR, 8'h0c | 8'(m));
         rdCtrl(8'h0c | 8'(m));
      end
      // External pin source, stopped: ticks come only from the pin
      wr(`TIMER_CTRL_ADDR, 8'h0c);
      rdCtrl(8'h0c);
      wr(`CMP_A_LO_ADDR, 8'h05);
      ticks(1);
      rd16(`CMP_A_LO_ADDR, 16'h0fff);
      wr(`CMP_A_HI_ADDR, 8'h00);
      rd16(`CMP_A_LO_ADDR, 16'h0fff);
      ticks(1);
      rd16(`CMP_A_LO_ADDR, 16'h0005);
      wr16(`CMP_B_LO_ADDR, 16'h0003);
      ticks(1);
      rd16(`CMP_B_LO_ADDR, 16'h0fff);
      // Command start, match at five
      wr(`TIMER_CTRL_ADDR, 8'h1c);
      rdCtrl(8'h1c);
      irqBase = irqCount;
      ticks(11);
      check(16'(irqCount - irqBase), 16'h0001);
      ticks(1);
      check(16'(irqCount - irqBase), 16'h0002);
      // Auto-capture from a fresh start
      wr(`TIMER_CTRL_ADDR, 8'h0c);
      wr(`TIMER_CTRL_ADDR, 8'h5c);
      ticks(3);
      rd16(`CMP_B_LO_ADDR, 16'h0002);
      // Power-down entry clears the start field
      stopModeEntry <= 1'b1;
      @(posedge sys_clk);
      stopModeEntry <= 1'b0;
      @(posedge sys_clk);
      rdCtrl(8'h4c);
      irqBase = irqCount;
      ticks(8);
      check(16'(irqCount - irqBase), 16'h0000);
      // Pulse output: mode first, then flip-flop, then B
      wr(`TIMER_CTRL_ADDR, 8'h0f);
      wr(`TIMER_CTRL_ADDR, 8'h8f);
      repeat (3) @(posedge sys_clk);
      check({15'h0000, timerOutput}, 16'h0001);
      wr16(`CMP_B_LO_ADDR, 16'h0003);
      ticks(1);
      rd16(`CMP_B_LO_ADDR, 16'h0003);
      // A=5 above B=3 above one, so output toggles twice a period
      wr(`TIMER_CTRL_ADDR, 8'h9f);
      ticks(5);
      check({15'h0000, timerOutput}, 16'h0000);
      ticks(1);
      check({15'h0000, timerOutput}, 16'h0001);
      wr(`TIMER_CTRL_ADDR, 8'h0f);
      repeat (3) @(posedge sys_clk);
      check({15'h0000, timerOutput}, 16'h0000);
      // Fast tap: silent in slow mode, then a tick every 16 cycles
      wr(`TIMER_CTRL_ADDR, 8'h08);
      slowMode <= 1'b1;
      wr(`TIMER_CTRL_ADDR, 8'h18);
      irqsIn(400, 0);
      slowMode <= 1'b0;
      irqsIn(400, 4);
      // Prescale halves the tap rate; changed only while stopped
      wr(`TIMER_CTRL_ADDR, 8'h08);
      prescaleSelect <= 1'b1;
      wr(`TIMER_CTRL_ADDR, 8'h18);
      irqsIn(400, 2);
      // Rising-edge trigger: one run up to the match, then halted
      wr(`TIMER_CTRL_ADDR, 8'h08);
      wr(`TIMER_CTRL_ADDR, 8'h28);
      irqsIn(200, 0);
      ticks(1);
      irqsIn(400, 1);
      // Window, negative logic: counts only while the pin is low
      wr(`TIMER_CTRL_ADDR, 8'h08);
      wr(`TIMER_CTRL_ADDR, 8'h09);
      wr(`TIMER_CTRL_ADDR, 8'h39);
      irqsIn(400, 2);
      timerInputPin <= 1'b1;
      irqsIn(400, 0);
      // Pulse width, single edge: falling start, rising capture, no A match
      wr(`TIMER_CTRL_ADDR, 8'h09);
      wr(`TIMER_CTRL_ADDR, 8'h4a);
      wr(`TIMER_CTRL_ADDR, 8'h7a);
      timerInputPin <= 1'b0;
      irqsIn(400, 0);
      timerInputPin <= 1'b1;
      irqsIn(40, 1);
      finalReport();
   end

   // ----------------------------------------
   // Hang guard
   // ----------------------------------------
   initial begin
      repeat (60000) @(posedge sys_clk);
      nErrors++;
      $display("BAD at %0t: run did not finish", $time);
      finalReport();
   end
endmodule

`default_nettype wire
